/* File: power_saving_mode_control_tb_top.sv */
/*
  self-checking bench of the power-saving mode controller.
  assumes the cpu model file and the design files are compiled first.
*/
`timescale 1ns/1ns
module power_saving_mode_control_tb_top;
  import psm_ctrl_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, sleepExec, isrEntry, isrExit, oscTick, flashReady, sysClkReady;
  logic [7:0] irqFlag = 8'h00, irqEnable = 8'h00;
  logic global_irq_enable = 0, wdExp = 0, xtal = 0, cpuClkEn, oscClkEn, oscQuarterEn, ioHold, wdClr, wdRun;
  logic devRst, vecReq, bor, clr, wdOn = 0, borReq = 0;
  logic [15:0] vec;
  psm_status_t st;
  int errors = 0, num_checks = 0, n;

  // 100 MHz system clock
  always #5 clk = ~clk;

  psm_ctrl #(.OST_CNT(4)) u_dut (.clk(clk), .rstn(rstn), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleepExec(sleepExec), .isrEntry(isrEntry),
    .isrExit(isrExit), .irqFlag(irqFlag), .irqEnable(irqEnable), .globalIrqEnable(global_irq_enable),
    .watchdogExpire(wdExp), .watchdogSleepOn(wdOn), .resetPinReq(1'b0), .brownoutReq(borReq),
    .brownoutEnable(1'b1), .brownoutReady(bor), .flashReady(flashReady),
    .sysClkReady(sysClkReady), .crystalOsc(xtal), .oscTick(oscTick), .cpuClkEn(cpuClkEn),
    .oscClkEn(oscClkEn), .oscQuarterEn(oscQuarterEn), .ioHold(ioHold), .watchdogClear(wdClr),
    .watchdogRun(wdRun), .deviceResetReq(devRst), .isrVectorReq(vecReq), .isrVector(vec),
    .status(st));

  psm_cpu_model u_cpu (.clk(clk), .rstn(rstn), .watchdogClear(wdClr), .sleepExec(sleepExec),
    .isrEntry(isrEntry), .isrExit(isrExit), .oscTick(oscTick), .flashReady(flashReady),
    .sysClkReady(sysClkReady), .brownoutReady(bor));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // apb transfer held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      errors++;
      end_of_test();
    end
    rd = pslverr ? 32'hFFFF_FFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for the core to run again; n holds the cycles taken
  // always steps one edge first: right after a pulse the state is not yet updated
  task automatic waitRun();
    n = 0;
    do
    begin
      @(posedge clk) #1;
      n++;
    end
    while (n < 300 && st.cpuRun !== 1'b1);
    if (st.cpuRun !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
    @(posedge clk);
  endtask

  task automatic t_regs();
    apb(0, 12'h28C, 0);
    chk(rd, 32'h0000_0000);
    apb(0, 12'h290, 0);
    chk(rd, 32'h0000_000C);
    apb(0, 12'h100, 0);
    chk(rd, 32'hFFFF_FFFF);
    apb(1, 12'h28C, 32'h0000_0035);
    apb(0, 12'h28C, 0);
    chk(rd, 32'h0000_0035);
    apb(1, 12'h28C, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_noop();
    irqFlag <= 8'h02;
    irqEnable <= 8'h02;
    u_cpu.pulse(0, clr);
    chk(clr, 0);
    @(posedge clk);
    chk({st.cpuRun, st.powerdownFlagN, st.watchdogExpiryFlagN}, 3'b111);
    irqFlag <= 8'h00;
    $display("test noop done");
  endtask

  // sleep, wake by interrupt; csw source must not wake
  task automatic t_sleep(input logic x, input logic g);
    xtal <= x;
    global_irq_enable <= g;
    wdOn <= x;
    irqEnable <= 8'h28;
    u_cpu.pulse(0, clr);
    chk(clr, 1);
    @(posedge clk);
    chk(wdRun, x);
    chk({st.cpuRun, st.powerdownFlagN, st.watchdogExpiryFlagN}, 3'b001);
    chk({cpuClkEn, oscClkEn, oscQuarterEn, ioHold}, 4'b0001);
    irqFlag <= 8'h08;
    repeat (10) @(posedge clk);
    chk(st.cpuRun, 0);
    irqFlag <= 8'h28;
    waitRun();
    chk(devRst, 0);
    if (x)
      chk(n >= 12, 1);
    else
      chk(n <= 3, 1);
    chk({vecReq, vec}, {g, 16'h0004});
    irqFlag <= 8'h00;
    global_irq_enable <= 1'b0;
    $display("test sleep done");
  endtask

  task automatic t_idle();
    xtal <= 1'b0;
    apb(1, 12'h28C, 32'h0000_0080);
    u_cpu.pulse(0, clr);
    @(posedge clk);
    chk({st.cpuRun, cpuClkEn, oscClkEn}, 3'b001);
    irqFlag <= 8'h20;
    waitRun();
    irqFlag <= 8'h00;
    apb(0, 12'h28C, 0);
    chk(rd, 32'h0000_0080);
    apb(1, 12'h28C, 32'h0000_00E0);
    u_cpu.pulse(0, clr);
    wdExp <= 1'b1;
    waitRun();
    wdExp <= 1'b0;
    chk({devRst, st.watchdogExpiryFlagN}, 2'b00);
    apb(0, 12'h28C, 0);
    chk(rd, 32'h0000_00E0);
    apb(1, 12'h28C, 32'h0000_0000);
    u_cpu.pulse(0, clr);
    wdExp <= 1'b1;
    @(posedge clk);
    wdExp <= 1'b0;
    @(posedge clk);
    chk(devRst, 1);
    waitRun();
    // brown-out request while asleep must also come back as a reset
    u_cpu.pulse(0, clr);
    borReq <= 1'b1;
    @(posedge clk);
    borReq <= 1'b0;
    @(posedge clk);
    chk(devRst, 1);
    waitRun();
    $display("test idle and watchdog done");
  endtask

  // throttle ratio sweep, then hardware set and clear around the isr
  task automatic t_throttle();
    int cnt;
    for (int r = 0; r < 3; r++)
    begin
      apb(1, 12'h28C, 32'h0000_0040 | r);
      cnt = 0;
      repeat (4 << r)
      begin
        #1 cnt += cpuClkEn;
        @(posedge clk);
      end
      chk(cnt, 2);
    end
    apb(1, 12'h28C, 32'h0000_0061);
    u_cpu.pulse(1, clr);
    apb(0, 12'h28C, 0);
    chk(rd, 32'h0000_0021);
    apb(1, 12'h28C, 32'h0000_0011);
    u_cpu.pulse(2, clr);
    apb(0, 12'h28C, 0);
    chk(rd, 32'h0000_0051);
    $display("test throttle done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_noop();
    t_sleep(0, 0);
    t_sleep(1, 1);
    t_idle();
    t_throttle();
    end_of_test();
  end
endmodule

/* File: psm_cpu_model.sv */
/*
  behavioural cpu core, interrupt return path and oscillator model.
  assumes the bench calls its pulse task from the clk domain only.
*/
`timescale 1ns/1ns
module psm_cpu_model
(
  input  wire logic clk,           // system clock
  input  wire logic rstn,          // active low reset
  input  wire logic watchdogClear, // sampled in the pulse cycle
  output logic      sleepExec,     // sleep instruction pulse
  output logic      isrEntry,      // isr entry pulse
  output logic      isrExit,       // isr exit pulse
  output logic      oscTick,       // one pulse per osc period
  output logic      flashReady,    // flash ready
  output logic      sysClkReady,   // clock ready
  output logic      brownoutReady  // brown-out circuit ready
);
  logic [1:0] tickCnt_q;
  logic       ready_q;

  initial
  begin
    sleepExec = 1'b0;
    isrEntry = 1'b0;
    isrExit = 1'b0;
  end

  // oscillator period of four clocks; readiness waits for the first one
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      tickCnt_q <= 2'h0;
      ready_q <= 1'b0;
    end
    else
    begin
      tickCnt_q <= tickCnt_q + 2'h1;
      ready_q <= ready_q | oscTick;
    end

  assign oscTick = (tickCnt_q == 2'h3);
  assign flashReady = ready_q;
  assign sysClkReady = ready_q;
  assign brownoutReady = ready_q;

  // one-cycle pulse: 0 sleep, 1 isr entry, 2 isr exit
  task automatic pulse(input int kind, output logic clrSeen);
    @(posedge clk);
    sleepExec <= (kind == 0);
    isrEntry <= (kind == 1);
    isrExit <= (kind == 2);
    #1 clrSeen = watchdogClear;
    @(posedge clk);
    // slot after sleep carries only a no-op, never a new pulse
    sleepExec <= 1'b0;
    isrEntry <= 1'b0;
    isrExit <= 1'b0;
  endtask
endmodule

/* File: psm_ctrl.sv */
/*
  power-saving mode controller: sleep, idle and throttle (doze) control
  with an apb register port. assumes the cpu core pulses sleepExec for one
  cycle, isrEntry/isrExit once per service routine, and that irq and
  readiness inputs come from the same clock domain except resetPinReq.
*/
`timescale 1ns/1ns
`include "psm_ctrl_map.svh"

module psm_ctrl
#(
  parameter int NUM_IRQ  = 8,       // interrupt sources
  parameter int CSW_IRQ  = 3,       // index of clock-switch interrupt
  parameter int OST_CNT  = `PSM_OST_PERIODS // start-up wait in osc periods
)
(
  input  wire logic                     clk,          // system clock 100 MHz
  input  wire logic                     rstn,         // any device reset
  input  wire logic                     clkEn,        // freezes all state when low
  input  wire logic                     psel,         // apb select
  input  wire logic                     penable,      // apb access phase
  input  wire logic                     pwrite,       // apb direction
  input  wire logic [11:0]              paddr,        // apb byte address
  input  wire logic [31:0]              pwdata,       // apb write data
  output logic      [31:0]              prdata,       // apb read data
  output logic                          pready,       // apb ready
  output logic                          pslverr,      // apb error
  input  wire logic                     sleepExec,    // sleep instruction pulse
  input  wire logic                     isrEntry,     // cpu enters isr pulse
  input  wire logic                     isrExit,      // cpu leaves isr pulse
  input  wire logic [NUM_IRQ-1:0]       irqFlag,      // interrupt flags
  input  wire logic [NUM_IRQ-1:0]       irqEnable,    // per_source_irq_enable
  input  wire logic                     globalIrqEnable, // global_irq_enable
  input  wire logic                     watchdogExpire, // watchdog_timer timeout
  input  wire logic                     watchdogSleepOn, // watchdog runs in sleep
  input  wire logic                     resetPinReq,  // external_reset_pin, async
  input  wire logic                     brownoutReq,  // brownout_reset or low-power
  input  wire logic                     brownoutEnable, // brown-out circuit in use
  input  wire logic                     brownoutReady, // brown-out circuit ready
  input  wire logic                     flashReady,   // program_flash ready
  input  wire logic                     sysClkReady,  // system clock ready
  input  wire logic                     crystalOsc,   // crystal-type oscillator
  input  wire logic                     oscTick,      // one oscillator_period pulse
  output logic                          cpuClkEn,     // cpu instruction cycle enable
  output logic                          oscClkEn,     // system_oscillator_clock gate
  output logic                          oscQuarterEn, // divided-by-4 clock gate
  output logic                          ioHold,       // freeze port outputs
  output logic                          watchdogClear, // clear watchdog and prescaler
  output logic                          watchdogRun,  // watchdog may count
  output logic                          deviceResetReq, // reset caused by wake source
  output logic                          isrVectorReq, // vector after next instr
  output logic      [15:0]              isrVector,    // vector address
  output psm_ctrl_pkg::psm_status_t     status        // flags and state
);
  import psm_ctrl_pkg::*;

  // register bits
  logic       idleSelect_q;
  logic       throttleEnable_q;
  logic       recoverOnIrq_q;
  logic       throttleOnExit_q;
  logic [2:0] ratio_q;
  logic       pdN_q;
  logic       toN_q;
  psm_state_t state_q;
  logic [10:0] ostCnt_q;
  logic [7:0]  thrCnt_q;
  logic        thrPrev_q;
  logic        rstPinMeta_q;
  logic        rstPinSync_q;
  logic        vecReq_q;
  logic        resetReq_q;

  // throttle period in cycles is 2 << ratio; returns it minus one
  function automatic logic [8:0] throttle_period(input logic [2:0] r);
    throttle_period = 9'(9'h002 << r) - 9'h001;
  endfunction

  wire logic [NUM_IRQ-1:0] wakeMask = irqFlag & irqEnable & ~(NUM_IRQ'(1) << CSW_IRQ);
  wire logic irqWake  = |wakeMask;
  wire logic sleeping = (state_q == PSM_SLEEP);
  wire logic idling   = (state_q == PSM_IDLE);
  wire logic hardReset = rstPinSync_q | brownoutReq;
  wire logic ready    = flashReady & sysClkReady &
                        (brownoutReady | ~brownoutEnable);
  wire logic enterSlp = (state_q == PSM_RUN) & sleepExec & ~irqWake;

  // apb decode, zero wait states
  wire logic access   = psel & penable;
  wire logic hitCtrl  = (paddr == `PSM_OFS_CTRL);
  wire logic hitStat  = (paddr == `PSM_OFS_STATUS);
  wire logic wrCtrl   = access & pwrite & hitCtrl;
  assign pready  = 1'b1;
  assign pslverr = access & ~(hitCtrl | hitStat);

  // read data registered on the setup cycle so it is stable in access
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (clkEn && psel && !penable && !pwrite)
    begin
      if (hitCtrl)
        prdata <= {24'h00_0000, idleSelect_q, throttleEnable_q, recoverOnIrq_q,
                   throttleOnExit_q, 1'b0, ratio_q};
      else if (hitStat)
        prdata <= {28'h000_0000, pdN_q, toN_q, ~(state_q == PSM_RUN), resetReq_q};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // software fields; idle_select is only changed by software
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idleSelect_q     <= 1'(`PSM_CTRL_RESET >> `PSM_BIT_IDLE);
      recoverOnIrq_q   <= 1'b0;
      throttleOnExit_q <= 1'b0;
      ratio_q          <= 3'h0;
    end
    else if (clkEn && wrCtrl)
    begin
      idleSelect_q     <= pwdata[`PSM_BIT_IDLE];
      recoverOnIrq_q   <= pwdata[`PSM_BIT_ROI];
      throttleOnExit_q <= pwdata[`PSM_BIT_DOE];
      ratio_q          <= pwdata[`PSM_RATIO_HI:`PSM_RATIO_LO];
    end
  end

  // throttle enable: hardware set/clear beats a software write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      throttleEnable_q <= 1'b0;
    else if (clkEn)
    begin
      if (isrEntry && recoverOnIrq_q)
        throttleEnable_q <= 1'b0;
      else if (isrExit && throttleOnExit_q)
        throttleEnable_q <= 1'b1;
      else if (wrCtrl)
        throttleEnable_q <= pwdata[`PSM_BIT_THR];
    end
  end

  // reset-pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstPinMeta_q <= 1'b0;
      rstPinSync_q <= 1'b0;
    end
    else if (clkEn)
    begin
      rstPinMeta_q <= resetPinReq;
      rstPinSync_q <= rstPinMeta_q;
    end
  end

  // mode sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= PSM_RUN;
    else if (clkEn)
    begin
      case (state_q)
        PSM_RUN:
          if (enterSlp)
            state_q <= idleSelect_q ? PSM_IDLE : PSM_SLEEP;
        PSM_SLEEP:
          if (irqWake || watchdogExpire || hardReset)
            state_q <= (crystalOsc && !hardReset) ? PSM_OSTW : PSM_WAKE;
        PSM_IDLE:
          if (irqWake || watchdogExpire || hardReset)
            state_q <= PSM_WAKE;
        PSM_OSTW:
          if (ostCnt_q == 11'(OST_CNT - 1) && oscTick)
            state_q <= PSM_WAKE;
        PSM_WAKE:
          if (ready)
            state_q <= PSM_RUN;
        default:
          state_q <= PSM_RUN;
      endcase
    end
  end

  // oscillator start-up counter, counts oscillator periods
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ostCnt_q <= 11'h000;
    else if (clkEn)
    begin
      if (state_q != PSM_OSTW)
        ostCnt_q <= 11'h000;
      else if (oscTick)
        ostCnt_q <= ostCnt_q + 11'h001;
    end
  end

  // status flags: active low; a real sleep clears pdN_q and sets toN_q, a watchdog expiry in sleep or idle without irqWake clears toN_q
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pdN_q <= 1'b1;
      toN_q <= 1'b1;
    end
    else if (clkEn)
    begin
      if (enterSlp)
      begin
        pdN_q <= 1'b0;
        toN_q <= 1'b1;
      end
      else if ((sleeping || idling) && watchdogExpire && !irqWake)
        toN_q <= 1'b0;
    end
  end

  // wake bookkeeping: vector request and reset cause
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vecReq_q   <= 1'b0;
      resetReq_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if ((sleeping || idling) && irqWake)
        vecReq_q <= globalIrqEnable;
      else if (isrEntry || enterSlp)
        vecReq_q <= 1'b0;
      if (sleeping && !idling && hardReset)
        resetReq_q <= 1'b1;
      else if (sleeping && watchdogExpire && !irqWake)
        resetReq_q <= 1'b1;
      else if (state_q == PSM_RUN)
        resetReq_q <= 1'b0;
    end
  end

  // throttle counter restarts on any enable change
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      thrCnt_q  <= 8'h00;
      thrPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      thrPrev_q <= throttleEnable_q;
      // the change cycle is itself slot zero, so counting goes on from one;
      // restarting at zero would hand out two slots back to back
      if (throttleEnable_q != thrPrev_q)
        thrCnt_q <= 8'h01;
      else if (9'(thrCnt_q) >= throttle_period(ratio_q))
        thrCnt_q <= 8'h00;
      else
        thrCnt_q <= thrCnt_q + 8'h01;
    end
  end

  wire logic thrSlot = !throttleEnable_q || (throttleEnable_q != thrPrev_q) ||
                       thrCnt_q == 8'h00;

  // clock gating; other clock sources are not touched here
  assign cpuClkEn      = (state_q == PSM_RUN) && thrSlot;
  assign oscClkEn      = !sleeping && state_q != PSM_OSTW;
  assign oscQuarterEn  = oscClkEn;
  assign ioHold        = sleeping;
  assign watchdogClear = enterSlp || ((sleeping || idling) && (irqWake || watchdogExpire))
                         || state_q == PSM_OSTW;
  assign watchdogRun   = !sleeping || watchdogSleepOn;
  assign deviceResetReq = resetReq_q;
  assign isrVectorReq  = vecReq_q && state_q == PSM_RUN;
  assign isrVector     = `PSM_ISR_VECTOR;
  assign status        = '{powerdownFlagN: pdN_q, watchdogExpiryFlagN: toN_q,
                           cpuRun: state_q == PSM_RUN, wakeReset: resetReq_q};

  // assertions
  a_sleep_entry: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && enterSlp && !idleSelect_q |=> state_q == PSM_SLEEP)
    else $error("sleep not entered");
  a_idle_entry: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && enterSlp && idleSelect_q |=> state_q == PSM_IDLE && oscClkEn)
    else $error("idle not entered");
  a_flags_set: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && enterSlp |=> !pdN_q && toN_q)
    else $error("flags wrong after sleep");
  a_nop_sleep: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && sleepExec && irqWake && state_q == PSM_RUN |=> $stable(pdN_q) && state_q == PSM_RUN)
    else $error("sleep not a no-op");
  a_clk_gated: assert property (@(posedge clk) disable iff (!rstn)
    sleeping |-> !cpuClkEn && !oscClkEn && ioHold)
    else $error("clocks run in sleep");
  a_wd_clear: assert property (@(posedge clk) disable iff (!rstn)
    sleeping && irqWake |-> watchdogClear)
    else $error("watchdog not cleared on wake");
  a_wake_ready: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && state_q == PSM_WAKE && !ready |=> state_q == PSM_WAKE)
    else $error("run before ready");
  a_roi_clear: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && isrEntry && recoverOnIrq_q |=> !throttleEnable_q)
    else $error("throttle not cleared");
  a_idle_keep: assert property (@(posedge clk) disable iff (!rstn)
    idling && clkEn && irqWake && !wrCtrl |=> idleSelect_q && state_q == PSM_WAKE)
    else $error("idle exit wrong");
  a_thr_slot: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && throttleEnable_q && ratio_q == 3'h0 && cpuClkEn && !isrEntry && !wrCtrl
    |=> clkEn |-> !cpuClkEn)
    else $error("throttle ratio wrong");

  c_sleep_wake: cover property (@(posedge clk) sleeping ##1 state_q == PSM_WAKE);
  c_idle_wake: cover property (@(posedge clk) idling ##1 state_q == PSM_WAKE);
  c_ost: cover property (@(posedge clk) state_q == PSM_OSTW ##1 state_q == PSM_WAKE);
  c_nop: cover property (@(posedge clk) state_q == PSM_RUN && sleepExec && irqWake);
endmodule

/* File: psm_ctrl_map.svh */
/*
  register map, field positions, reset values and timing counts of the
  power-saving mode controller. assumes byte addressing on a 32-bit APB.
*/
`ifndef PSM_CTRL_MAP_SVH
`define PSM_CTRL_MAP_SVH
`define PSM_OFS_CTRL      12'h028C
`define PSM_OFS_STATUS    12'h0290
`define PSM_CTRL_RESET    8'h00
`define PSM_BIT_IDLE      7
`define PSM_BIT_THR       6
`define PSM_BIT_ROI       5
`define PSM_BIT_DOE       4
`define PSM_RATIO_HI      2
`define PSM_RATIO_LO      0
`define PSM_OST_PERIODS   1024
`define PSM_ISR_VECTOR    16'h0004
`endif

/* File: psm_ctrl_pkg.sv */
/*
  types of the power-saving mode controller.
  assumes the map header supplies all numbers.
*/
package psm_ctrl_pkg;
  typedef enum logic [2:0]
  {
    PSM_RUN   = 3'b000,
    PSM_SLEEP = 3'b001,
    PSM_IDLE  = 3'b010,
    PSM_WAKE  = 3'b011,
    PSM_OSTW  = 3'b100
  } psm_state_t;

  // status toward the cpu and watchdog
  typedef struct packed
  {
    logic powerdownFlagN;
    logic watchdogExpiryFlagN;
    logic cpuRun;
    logic wakeReset;
  } psm_status_t;
endpackage
